// [design/otpc_ctrl.sv]
`timescale 1ns/1ps
`include "otpc_defs.svh"
module otpc_ctrl #(
  parameter logic [15:0] PROG_NORM_CYC = `OTPC_PROG_NORM_CYC,
  parameter logic [15:0] PROG_FAST_CYC = `OTPC_PROG_FAST_CYC,
  parameter logic [15:0] TWR_NORM_CYC  = `OTPC_TWR_NORM_CYC,
  parameter logic [15:0] TWR_FAST_CYC  = `OTPC_TWR_FAST_CYC
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Serial interface mode write
  input  wire logic        SER_MODE_WE,
  input  wire logic [31:0] SER_MODE_WDATA,
  // Trim registers for the alternate port
  input  wire logic [15:0] REF_TRIM,
  input  wire logic [15:0] RSSI_TRIM,
  input  wire logic [7:0]  RFIO_TRIM,
  input  wire logic [4:0]  LNA3_TRIM,
  input  wire logic [11:0] LNA2_TRIM,
  input  wire logic [11:0] LNA1_TRIM,
  input  wire logic [3:0]  OSC_TRIM,
  // FIFO and DMA
  input  wire logic        FIFO_RVALID,
  input  wire logic [31:0] FIFO_RDATA,
  output logic             FIFO_RREADY,
  output logic             FIFO_FLUSH,
  output logic             DMA_EN,
  // Macrocell banks
  output logic      [2:0]  OTP_MODE,
  output logic      [12:0] OTP_ADDR,
  output logic             OTP_RD_STB,
  output logic             OTP_PROG_ACT,
  output logic      [31:0] OTP_PROG_DATA,
  output logic             OTP_PROG_UEN,
  output logic             OTP_PROG_LEN,
  output logic             OTP_PROG_BITU,
  output logic             OTP_PROG_FAST
);

  // Mode register state
  logic [2:0]  mode_r;
  logic        dma_r;
  logic        flush_r;
  logic        pace_r;
  logic        src_r;
  logic        fast_r;
  logic [1:0]  mux_r;
  // Program control state
  logic        uen_r;
  logic        bitu_r;
  logic        len_r;
  logic [12:0] waddr_r;
  logic [12:0] wcnt_r;
  // Bus answer
  logic [31:0] prdata_r;
  logic        err_r;
  // Sequencer
  otpc_pkg::otpc_state_type state_r;
  otpc_pkg::otpc_state_type state_nxt;
  logic [2:0]  prev_mode_r;
  logic [12:0] words_r;
  logic [12:0] words_nxt;
  logic [12:0] addr_r;
  logic [12:0] addr_nxt;
  logic [31:0] pdata_r;
  logic [31:0] pdata_nxt;
  logic        manual_r;
  logic        manual_nxt;
  logic        rd_stb_r;
  logic        half_r;
  logic [31:0] mode_rd_w;
  logic [31:0] pctrl_rd_w;
  logic [31:0] stat_rd_w;
  logic [31:0] alt_word;
  logic        tmr_done;

  function automatic logic is_read(input logic [2:0] m);
    is_read = (m == `OTPC_M_MANUAL_READ_MODE) || (m == `OTPC_M_AUTOMATIC_READ_MODE);
  endfunction

  function automatic logic is_auto(input logic [2:0] m);
    is_auto = (m == `OTPC_M_AUTOMATIC_READ_MODE) || (m == `OTPC_M_AUTOMATIC_PROGRAM_MODE);
  endfunction

  // Bus decode
  wire logic apb_setup = PSEL && !PENABLE;
  wire logic apb_wr    = PSEL && PENABLE && PWRITE;
  wire logic hit_mode  = PADDR == `OTPC_MODE_ADDR;
  wire logic hit_pctrl = PADDR == `OTPC_PCTRL_ADDR;
  wire logic hit_wcnt  = PADDR == `OTPC_WCNT_ADDR;
  wire logic hit_stat  = PADDR == `OTPC_STAT_ADDR;
  wire logic hit_any   = hit_mode || hit_pctrl || hit_wcnt || hit_stat;
  wire logic apb_mode_we  = apb_wr && hit_mode;
  wire logic apb_pctrl_we = apb_wr && hit_pctrl;
  wire logic apb_wcnt_we  = apb_wr && hit_wcnt;

  // Bus write wins when the serial path writes in the same cycle
  wire logic        ser_we     = SER_MODE_WE && !apb_mode_we;
  wire logic        mode_we    = apb_mode_we || ser_we;
  wire logic [31:0] mode_wdata = apb_mode_we ? PWDATA : SER_MODE_WDATA;
  wire logic        dma_nxt    = apb_mode_we ? PWDATA[`OTPC_DMA_BIT] :
                                 ser_we ? 1'b0 : dma_r;

  // Mode decode
  wire logic automatic_program_mode_w = mode_r == `OTPC_M_AUTOMATIC_PROGRAM_MODE;
  wire logic manual_program_mode_w = mode_r == `OTPC_M_MANUAL_PROGRAM_MODE;
  wire logic read_w  = is_read(mode_r);
  wire logic enter_automatic_program_mode = automatic_program_mode_w && (prev_mode_r != `OTPC_M_AUTOMATIC_PROGRAM_MODE);
  wire logic manual_program_mode_start = apb_pctrl_we && manual_program_mode_w;

  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_r;
  assign PSLVERR = PSEL && PENABLE && err_r;

  // Unnamed bits stay zero in every readback word
  always_comb begin
    mode_rd_w = `OTPC_RST_WORD;
    mode_rd_w[`OTPC_MODE_MSB:`OTPC_MODE_LSB] = mode_r;
    mode_rd_w[`OTPC_DMA_BIT]   = dma_r;
    mode_rd_w[`OTPC_FLUSH_BIT] = flush_r;
    mode_rd_w[`OTPC_PACE_BIT]  = pace_r;
    mode_rd_w[`OTPC_SRC_BIT]   = src_r;
    mode_rd_w[`OTPC_FAST_BIT]  = fast_r;
    mode_rd_w[`OTPC_MUX_MSB:`OTPC_MUX_LSB] = mux_r;
    pctrl_rd_w = `OTPC_RST_WORD;
    pctrl_rd_w[`OTPC_ENU_BIT]  = uen_r;
    pctrl_rd_w[`OTPC_BITU_BIT] = bitu_r;
    pctrl_rd_w[`OTPC_ENL_BIT]  = len_r;
    pctrl_rd_w[`OTPC_WADDR_MSB:0] = waddr_r;
    stat_rd_w = `OTPC_RST_WORD;
    stat_rd_w[`OTPC_WADDR_MSB:0] = words_r;
    stat_rd_w[`OTPC_STAT_ST_MSB:`OTPC_STAT_ST_LSB] = state_r;
  end

  wire logic [31:0] rd_sel = hit_mode  ? mode_rd_w :
                             hit_pctrl ? pctrl_rd_w :
                             hit_wcnt  ? {19'h00000, wcnt_r} :
                             hit_stat  ? stat_rd_w : `OTPC_RST_WORD;

  // Read data captured in setup so access completes without wait
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r <= `OTPC_RST_WORD;
      err_r    <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= rd_sel;
      err_r    <= !hit_any;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= `OTPC_M_STANDBY_MODE;
      pace_r <= 1'b0;
      src_r  <= 1'b0;
      fast_r <= 1'b0;
      mux_r  <= `OTPC_MUX_REF;
    end else if (mode_we) begin
      mode_r <= mode_wdata[`OTPC_MODE_MSB:`OTPC_MODE_LSB];
      pace_r <= mode_wdata[`OTPC_PACE_BIT];
      src_r  <= mode_wdata[`OTPC_SRC_BIT];
      fast_r <= mode_wdata[`OTPC_FAST_BIT];
      mux_r  <= mode_wdata[`OTPC_MUX_MSB:`OTPC_MUX_LSB];
    end
  end

  // Flush lasts one cycle, so the bit reads back as zero afterwards
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      dma_r   <= 1'b0;
      flush_r <= 1'b0;
    end else begin
      dma_r   <= dma_nxt;
      flush_r <= mode_we && mode_wdata[`OTPC_FLUSH_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      uen_r   <= 1'b0;
      bitu_r  <= 1'b0;
      len_r   <= 1'b0;
      waddr_r <= 13'h0000;
      wcnt_r  <= 13'h0000;
    end else begin
      if (apb_pctrl_we) begin
        uen_r   <= PWDATA[`OTPC_ENU_BIT];
        bitu_r  <= PWDATA[`OTPC_BITU_BIT];
        len_r   <= PWDATA[`OTPC_ENL_BIT];
        waddr_r <= PWDATA[`OTPC_WADDR_MSB:0];
      end
      if (apb_wcnt_we) begin
        wcnt_r <= PWDATA[`OTPC_WADDR_MSB:0];
      end
    end
  end

  otpc_altmux u_altmux (
    .sel       (mux_r),
    .ref_trim  (REF_TRIM),
    .rssi_trim (RSSI_TRIM),
    .rfio_trim (RFIO_TRIM),
    .lna3_trim (LNA3_TRIM),
    .lna2_trim (LNA2_TRIM),
    .lna1_trim (LNA1_TRIM),
    .osc_trim  (OSC_TRIM),
    .word      (alt_word)
  );

  // Program sequencer
  wire logic fifo_take = FIFO_RREADY && FIFO_RVALID;
  wire logic tmr_start = (state_nxt == otpc_pkg::ST_PROG ||
                          state_nxt == otpc_pkg::ST_RECOV) &&
                         (state_nxt != state_r);
  wire logic tmr_recov = state_nxt == otpc_pkg::ST_RECOV;

  assign FIFO_RREADY = (state_r == otpc_pkg::ST_FETCH) &&
                       automatic_program_mode_w && !src_r;

  always_comb begin
    state_nxt  = state_r;
    words_nxt  = words_r;
    addr_nxt   = addr_r;
    pdata_nxt  = pdata_r;
    manual_nxt = manual_r;
    case (state_r)
      otpc_pkg::ST_IDLE: begin
        addr_nxt = waddr_r;
        if (manual_program_mode_start) begin
          addr_nxt   = PWDATA[`OTPC_WADDR_MSB:0];
          pdata_nxt  = `OTPC_RST_WORD;
          words_nxt  = 13'h0001;
          manual_nxt = 1'b1;
          state_nxt  = otpc_pkg::ST_PROG;
        end else if (enter_automatic_program_mode) begin
          manual_nxt = 1'b0;
          words_nxt  = src_r ? 13'h0001 : wcnt_r;
          if (src_r || wcnt_r != 13'h0000) begin
            state_nxt = otpc_pkg::ST_FETCH;
          end
        end else if (mode_r == `OTPC_M_AUTOMATIC_READ_MODE) begin
          addr_nxt = addr_r + {12'h000, rd_stb_r && half_r};
        end
      end
      otpc_pkg::ST_FETCH: begin
        if (!automatic_program_mode_w) begin
          state_nxt = otpc_pkg::ST_IDLE;
        end else if (src_r) begin
          pdata_nxt = alt_word;
          state_nxt = otpc_pkg::ST_PROG;
        end else if (fifo_take) begin
          pdata_nxt = FIFO_RDATA;
          state_nxt = otpc_pkg::ST_PROG;
        end
      end
      otpc_pkg::ST_PROG: begin
        if (tmr_done) begin
          state_nxt = otpc_pkg::ST_RECOV;
        end
      end
      otpc_pkg::ST_RECOV: begin
        if (tmr_done) begin
          words_nxt = words_r - 13'h0001;
          if (manual_r || words_r == 13'h0001 || !automatic_program_mode_w) begin
            state_nxt = otpc_pkg::ST_IDLE;
          end else begin
            addr_nxt  = addr_r + 13'h0001;
            state_nxt = otpc_pkg::ST_FETCH;
          end
        end
      end
      default: begin
        state_nxt = otpc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r     <= otpc_pkg::ST_IDLE;
      prev_mode_r <= `OTPC_M_STANDBY_MODE;
      words_r     <= 13'h0000;
      addr_r      <= 13'h0000;
      pdata_r     <= `OTPC_RST_WORD;
      manual_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      prev_mode_r <= mode_r;
      words_r     <= words_nxt;
      addr_r      <= addr_nxt;
      pdata_r     <= pdata_nxt;
      manual_r    <= manual_nxt;
    end
  end

  otpc_timer #(
    .PROG_NORM_CYC (PROG_NORM_CYC),
    .PROG_FAST_CYC (PROG_FAST_CYC),
    .TWR_NORM_CYC  (TWR_NORM_CYC),
    .TWR_FAST_CYC  (TWR_FAST_CYC)
  ) u_timer (
    .mclk  (MCLK),
    .rst_n (RST_N),
    .start (tmr_start),
    .recov (tmr_recov),
    .fast  (fast_r),
    .done  (tmr_done)
  );

  // Read pacing; half_r pairs two 16-bit reads into one word
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_stb_r <= 1'b0;
      half_r   <= 1'b0;
    end else begin
      rd_stb_r <= read_w && (!pace_r || !rd_stb_r);
      if (!read_w) begin
        half_r <= 1'b0;
      end else if (rd_stb_r) begin
        half_r <= !half_r;
      end
    end
  end

  // Macrocell and DMA outputs
  wire logic prog_act = state_r == otpc_pkg::ST_PROG;
  assign OTP_MODE      = mode_r;
  assign OTP_ADDR      = addr_r;
  assign OTP_RD_STB    = rd_stb_r;
  assign OTP_PROG_ACT  = prog_act;
  assign OTP_PROG_DATA = pdata_r;
  assign OTP_PROG_UEN  = prog_act && uen_r;
  assign OTP_PROG_LEN  = prog_act && len_r;
  assign OTP_PROG_BITU = bitu_r;
  assign OTP_PROG_FAST = fast_r;
  assign FIFO_FLUSH    = flush_r;
  // Base address must already be set by software when this rises
  assign DMA_EN = dma_r && is_auto(mode_r) &&
                  !(automatic_program_mode_w && src_r);

  a_dma_alt_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    (automatic_program_mode_w && src_r) |-> !DMA_EN)
    else $error("DMA active with alternate port source");

  a_dma_path: assert property (@(posedge MCLK) disable iff (!RST_N)
    DMA_EN |-> dma_r && (mode_r == `OTPC_M_AUTOMATIC_READ_MODE ||
                         mode_r == `OTPC_M_AUTOMATIC_PROGRAM_MODE))
    else $error("DMA enabled outside auto mode");

  a_serial_dma: assert property (@(posedge MCLK) disable iff (!RST_N)
    (SER_MODE_WE && !apb_mode_we) |=> !dma_r && !DMA_EN)
    else $error("Serial mode write left DMA select set");

  a_flush_pulse: assert property (@(posedge MCLK) disable iff (!RST_N)
    (apb_mode_we && PWDATA[`OTPC_FLUSH_BIT] && !SER_MODE_WE)
    |=> FIFO_FLUSH ##1 !FIFO_FLUSH)
    else $error("Flush did not pulse for one cycle");

  a_read_slow: assert property (@(posedge MCLK) disable iff (!RST_N)
    (OTP_RD_STB && pace_r && $stable(pace_r)) |=> !OTP_RD_STB)
    else $error("Paced read strobe came back to back");

  a_read_fast: assert property (@(posedge MCLK) disable iff (!RST_N)
    (read_w && !pace_r && $past(read_w) && !$past(pace_r))
    |-> OTP_RD_STB)
    else $error("Unpaced read skipped a cycle");

  a_alt_single: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state_r == otpc_pkg::ST_IDLE && enter_automatic_program_mode && src_r &&
     !manual_program_mode_start) |=> words_r == 13'h0001 ##1 pdata_r == $past(alt_word))
    else $error("Alternate source did not load a single word");

  a_fifo_source: assert property (@(posedge MCLK) disable iff (!RST_N)
    FIFO_RREADY |-> automatic_program_mode_w && !src_r)
    else $error("FIFO drained outside FIFO sourced programming");

  a_prog_fast: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($rose(prog_act) && fast_r && $stable(fast_r))
    |-> prog_act[*4] ##1 !prog_act)
    else $error("Fast program pulse length wrong");

  a_prog_norm: assert property (@(posedge MCLK) disable iff (!RST_N)
    ($rose(prog_act) && !fast_r && $stable(fast_r))
    |-> prog_act[*8] ##1 !prog_act)
    else $error("Normal program pulse length wrong");

  a_upper_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    OTP_PROG_UEN |-> prog_act && uen_r)
    else $error("Upper bank driven while disabled");

  a_lower_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    OTP_PROG_LEN |-> prog_act && len_r)
    else $error("Lower bank driven while disabled");

  a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (apb_setup && hit_mode) |=> PRDATA[31:30] == 2'h0 &&
                                PRDATA[27:9] == 19'h00000)
    else $error("Reserved mode bits read nonzero");

endmodule

// [design/otpc_defs.svh]
`ifndef OTPC_DEFS_SVH
`define OTPC_DEFS_SVH

// Register byte addresses
`define OTPC_MODE_ADDR     32'h40008000
`define OTPC_PCTRL_ADDR    32'h40008004
`define OTPC_WCNT_ADDR     32'h40008020
`define OTPC_STAT_ADDR     32'h40008024
`define OTPC_RST_WORD      32'h00000000

// Mode register fields
`define OTPC_MODE_MSB      2
`define OTPC_MODE_LSB      0
`define OTPC_DMA_BIT       4
`define OTPC_FLUSH_BIT     5
`define OTPC_PACE_BIT      6
`define OTPC_SRC_BIT       7
`define OTPC_FAST_BIT      8
`define OTPC_MUX_MSB       29
`define OTPC_MUX_LSB       28

// Program control fields
`define OTPC_ENU_BIT       27
`define OTPC_BITU_BIT      26
`define OTPC_ENL_BIT       25
`define OTPC_WADDR_MSB     12

// Status register fields
`define OTPC_STAT_ST_MSB   17
`define OTPC_STAT_ST_LSB   16

// Operating mode codes
`define OTPC_M_STANDBY_MODE        3'h0
`define OTPC_M_MANUAL_READ_MODE       3'h1
`define OTPC_M_MANUAL_PROGRAM_MODE       3'h2
`define OTPC_M_AUTOMATIC_READ_MODE       3'h3
`define OTPC_M_AUTOMATIC_PROGRAM_MODE       3'h4

// Alternate port sources
`define OTPC_MUX_REF       2'h0
`define OTPC_MUX_RSSI      2'h1
`define OTPC_MUX_LNA       2'h2
`define OTPC_MUX_OSC       2'h3

// Timing counts in MCLK cycles
`define OTPC_PROG_NORM_CYC 16'h0008
`define OTPC_PROG_FAST_CYC 16'h0004
`define OTPC_TWR_NORM_CYC  16'h0004
`define OTPC_TWR_FAST_CYC  16'h0002

`endif

// [design/otpc_pkg.sv]
package otpc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_PROG,
    ST_RECOV
  } otpc_state_type;

endpackage

// [design/otpc_altmux.sv]
`timescale 1ns/1ps
`include "otpc_defs.svh"
module otpc_altmux (
  // Selection
  input  wire logic [1:0]  sel,
  // Trim sources
  input  wire logic [15:0] ref_trim,
  input  wire logic [15:0] rssi_trim,
  input  wire logic [7:0]  rfio_trim,
  input  wire logic [4:0]  lna3_trim,
  input  wire logic [11:0] lna2_trim,
  input  wire logic [11:0] lna1_trim,
  input  wire logic [3:0]  osc_trim,
  // Alternate programming word
  output logic      [31:0] word
);

  wire logic [31:0] ref_w  = {16'h0000, ref_trim};
  wire logic [31:0] rssi_w = {rssi_trim, 8'h00, rfio_trim};
  wire logic [31:0] lna_w  = {3'h0, lna3_trim, lna2_trim, lna1_trim};
  wire logic [31:0] osc_w  = {28'h0000000, osc_trim};

  assign word = (sel == `OTPC_MUX_REF)  ? ref_w  :
                (sel == `OTPC_MUX_RSSI) ? rssi_w :
                (sel == `OTPC_MUX_LNA)  ? lna_w  : osc_w;

endmodule

// [design/otpc_timer.sv]
`timescale 1ns/1ps
`include "otpc_defs.svh"
module otpc_timer #(
  parameter logic [15:0] PROG_NORM_CYC = `OTPC_PROG_NORM_CYC,
  parameter logic [15:0] PROG_FAST_CYC = `OTPC_PROG_FAST_CYC,
  parameter logic [15:0] TWR_NORM_CYC  = `OTPC_TWR_NORM_CYC,
  parameter logic [15:0] TWR_FAST_CYC  = `OTPC_TWR_FAST_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic recov,
  input  wire logic fast,
  // Expiry
  output logic      done
);

  logic [15:0] cnt_r;
  logic        busy_r;

  wire logic [15:0] prog_cyc = fast ? PROG_FAST_CYC : PROG_NORM_CYC;
  wire logic [15:0] twr_cyc  = fast ? TWR_FAST_CYC : TWR_NORM_CYC;
  wire logic [15:0] load_w   = (recov ? twr_cyc : prog_cyc) - 16'h0001;

  assign done = busy_r && (cnt_r == 16'h0000);

  // Start wins over expiry so back to back phases chain cleanly
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
    end else if (start) begin
      cnt_r  <= load_w;
      busy_r <= 1'b1;
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r  <= cnt_r - 16'h0001;
    end
  end

endmodule

// [verification/otpc_fifo_model.sv]
`timescale 1ns/1ps
module otpc_fifo_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bench side loading
  input  wire logic        push,
  input  wire logic [31:0] pdata,
  input  wire logic        stall,
  // Controller side
  input  wire logic        rready,
  input  wire logic        flush,
  output logic             rvalid,
  output logic      [31:0] rdata
);
  logic [31:0] mem [8];
  logic [31:0] last_r;
  logic [3:0]  wp_r;
  logic [3:0]  rp_r;

  assign rvalid = !stall && (wp_r != rp_r);
  // Idle data line flips so a stale word is never taken as fresh
  assign rdata  = rvalid ? mem[rp_r[2:0]] : ~last_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {wp_r, rp_r, last_r} <= {8'h00, 32'h00000000};
    end else if (flush) begin
      rp_r <= wp_r;
    end else begin
      if (push) begin
        mem[wp_r[2:0]] <= pdata;
        wp_r <= wp_r + 4'h1;
      end
      if (rready && rvalid) begin
        last_r <= mem[rp_r[2:0]];
        rp_r <= rp_r + 4'h1;
      end
    end
  end
endmodule

// [verification/otp_mode_and_program_control_bench.sv]
`timescale 1ns/1ps
`include "otpc_defs.svh"
module otp_mode_and_program_control_bench;
  logic        mclk, rst_n, psel, penable, pwrite, ser_we, push, stall;
  logic [31:0] paddr, pwdata, ser_wd, pdata, rdat, pd, prdata, fdat, prog;
  logic        serr, pready, pslverr, rready, flush, dma_en, rd_stb, pact;
  logic        uen, len, bitu, fast, rvalid;
  logic [2:0]  otp_mode;
  logic [12:0] otp_addr, pa;
  logic [3:0]  pf;
  int          pn, s, err_total, checks_done;
  logic [15:0] ref_t  = 16'hA5C3;
  logic [15:0] rssi_t = 16'h1234;
  logic [7:0]  rfio_t = 8'h56;
  logic [4:0]  lna3_t = 5'h15;
  logic [11:0] lna2_t = 12'hABC;
  logic [11:0] lna1_t = 12'hDEF;
  logic [3:0]  osc_t  = 4'h9;
  // Row: alt source, fast bit, expected programmed word
  logic [34:0] rows [4] = '{{2'h0, 1'b0, 32'h0000A5C3},
    {2'h1, 1'b1, 32'h12340056}, {2'h2, 1'b0, 32'h15ABCDEF},
    {2'h3, 1'b1, 32'h00000009}};

  otpc_ctrl otpc_ctrl_i (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SER_MODE_WE(ser_we), .SER_MODE_WDATA(ser_wd), .REF_TRIM(ref_t),
    .RSSI_TRIM(rssi_t), .RFIO_TRIM(rfio_t), .LNA3_TRIM(lna3_t),
    .LNA2_TRIM(lna2_t), .LNA1_TRIM(lna1_t), .OSC_TRIM(osc_t),
    .FIFO_RVALID(rvalid), .FIFO_RDATA(fdat), .FIFO_RREADY(rready),
    .FIFO_FLUSH(flush), .DMA_EN(dma_en), .OTP_MODE(otp_mode),
    .OTP_ADDR(otp_addr), .OTP_RD_STB(rd_stb), .OTP_PROG_ACT(pact),
    .OTP_PROG_DATA(prog), .OTP_PROG_UEN(uen), .OTP_PROG_LEN(len),
    .OTP_PROG_BITU(bitu), .OTP_PROG_FAST(fast));
  otpc_fifo_model otpc_fifo_model_i (.clk(mclk), .rst_n(rst_n),
    .push(push), .pdata(pdata), .stall(stall), .rready(rready),
    .flush(flush), .rvalid(rvalid), .rdata(fdat));

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    {rdat, serr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task waitp;
    int i;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (pact !== 1'b1 && i < 300);
    {pd, pa, pf, pn} = {prog, otp_addr, uen, len, bitu, fast, 32'd0};
    while (pact === 1'b1 && pn < 300) begin
      pn++;
      @(negedge mclk);
    end
  endtask
  task cnt;
    s = 0;
    repeat (2) @(negedge mclk);
    repeat (8) begin
      @(negedge mclk);
      s += rd_stb;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  initial begin
    {rst_n, psel, penable, pwrite, ser_we, push, stall} = 7'h00;
    {paddr, pwdata, ser_wd, pdata} = {4{32'h00000000}};
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    apb(0, `OTPC_MODE_ADDR, 0);
    chk(rdat, 32'h00000000);
    apb(0, `OTPC_PCTRL_ADDR, 0);
    chk(rdat, 32'h00000000);
    apb(0, 32'h40008010, 0);
    chk({serr, rdat}, 33'h100000000);
    $display("reset test done");
    apb(1, `OTPC_WCNT_ADDR, 3);
    @(posedge mclk);
    {push, pdata} <= {1'b1, 32'h5A5A0F0F};
    @(posedge mclk);
    push <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1, `OTPC_MODE_ADDR, 0);
      apb(1, `OTPC_MODE_ADDR, {2'b0, rows[k][34:33], 19'h0, rows[k][32],
        8'h94});
      @(negedge mclk);
      chk(dma_en, 0);
      waitp();
      chk(pd, rows[k][31:0]);
      chk(pn, rows[k][32] ? `OTPC_PROG_FAST_CYC : `OTPC_PROG_NORM_CYC);
      chk(pf[0], rows[k][32]);
    end
    s = 0;
    repeat (40) begin
      @(negedge mclk);
      s += pact;
    end
    chk(s, 0);
    chk(rvalid, 1);
    $display("alternate port test done");
    for (int m = 0; m < 8; m++) begin
      apb(1, `OTPC_MODE_ADDR, 0);
      apb(1, `OTPC_MODE_ADDR, m);
      cnt();
      chk(otp_mode, m);
      chk(s, (m == 1 || m == 3) ? 8 : 0);
    end
    apb(1, `OTPC_MODE_ADDR, 0);
    // Bus base address lives outside this block and is taken as set
    apb(1, `OTPC_MODE_ADDR, 32'h13);
    @(negedge mclk);
    chk(dma_en, 1);
    apb(1, `OTPC_MODE_ADDR, 0);
    apb(1, `OTPC_MODE_ADDR, 32'h43);
    cnt();
    chk(s, 4);
    chk(dma_en, 0);
    apb(1, `OTPC_MODE_ADDR, 0);
    @(posedge mclk);
    {ser_we, ser_wd} <= {1'b1, 32'h00000013};
    @(posedge mclk);
    ser_we <= 1'b0;
    @(negedge mclk);
    chk(dma_en, 0);
    apb(0, `OTPC_MODE_ADDR, 0);
    chk(rdat, 32'h00000003);
    $display("mode test done");
    apb(1, `OTPC_MODE_ADDR, 0);
    @(posedge mclk);
    {push, pdata} <= {1'b1, 32'h0F0F5A5A};
    @(posedge mclk);
    push <= 1'b0;
    apb(1, `OTPC_MODE_ADDR, 32'hFFFFFFF8);
    @(negedge mclk);
    chk(flush, 1);
    @(negedge mclk);
    chk({flush, rvalid}, 0);
    apb(0, `OTPC_MODE_ADDR, 0);
    chk(rdat, 32'h300001D0);
    apb(1, `OTPC_PCTRL_ADDR, 32'hFFFFFFFF);
    apb(0, `OTPC_PCTRL_ADDR, 0);
    chk(rdat, 32'h0E001FFF);
    apb(1, `OTPC_MODE_ADDR, 0);
    $display("reserved and flush test done");
    apb(1, `OTPC_WCNT_ADDR, 2);
    apb(1, `OTPC_PCTRL_ADDR, 32'h0C000100);
    @(posedge mclk);
    {push, stall, pdata} <= {2'b11, 32'hC0DE0001};
    @(posedge mclk);
    pdata <= 32'hC0DE0002;
    @(posedge mclk);
    push <= 1'b0;
    apb(1, `OTPC_MODE_ADDR, 4);
    repeat (10) @(negedge mclk);
    chk(pact, 0);
    @(posedge mclk);
    stall <= 1'b0;
    waitp();
    chk(pd, 32'hC0DE0001);
    chk(pa, 13'h0100);
    chk(pf, 4'hA);
    waitp();
    chk(pd, 32'hC0DE0002);
    chk(pa, 13'h0101);
    $display("fifo program test done");
    apb(1, `OTPC_MODE_ADDR, 0);
    apb(1, `OTPC_MODE_ADDR, 2);
    apb(1, `OTPC_PCTRL_ADDR, 32'h02001FFF);
    waitp();
    chk(pa, 13'h1FFF);
    chk(pf, 4'h4);
    chk(pn, `OTPC_PROG_NORM_CYC);
    $display("manual program test done");
    end_sim();
  end
endmodule
